// ---- logic/wif_flags.sv ----
// Purpose: Wake-source and interrupt flag register with live input view
// Assumes: Register port on mclk; pushbutton, lock and ext inputs are async
// Notes:   Read data is registered, valid the cycle after rd
// Notes:   Pin edges show four to five edges late, a cost of the glitch filter
// Notes:   Flags are plain flip-flops; wake keeps them, rstn, zero writes and sleep (bit four) clear them
// Notes on behaviour
// - Pushbutton rising edge sets flag, zero write clears
// - Sleep request clears pushbutton flag
// - Pushbutton flag survives wake; reset, sleep or zero write clears it
// - Lock rise sets return flag, pulses power event
// - Lock fall sets loss flag, pulses power event
// - Pushbutton or timer wakes never set loss flag
// - Autowake expiry sets timer flag until cleared
// - Transfer-busy and second events set their flags
// - Two collision flags at bits two and three
// - Live field shows present ext input levels
// - Watchdog enable bit zero, serial enable bit four
`timescale 1ns/1ns
`default_nettype none
module wif_flags
  import wif_pkg::*;
#(
  parameter int unsigned N_EXT = NUM_EXT_INT
) (
  input  wire logic             mclk,
  input  wire logic             rstn,
  input  wire wif_req_t         req,
  input  wire wif_evt_t         evt,
  input  wire logic             pushbutton_input,
  input  wire logic             pll_locked,
  input  wire logic [N_EXT-1:0] ext_int_in,
  output logic      [7:0]       rdata,
  output logic                  power_event_interrupt,
  output logic                  watchdog_near_overflow_irq_en,
  output logic                  serial_port_irq_en
);

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers: three stages, change taken when stages 2 and 3 agree
  // Agreement costs a cycle but stops a metastable sample from making an edge
  logic [2:0]       pb_s_q;
  logic [2:0]       lk_s_q;
  logic [2:0]       ext_s_q [N_EXT];
  logic             pb_lvl_q;
  logic             lk_lvl_q;
  logic [N_EXT-1:0] ext_lvl_q;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pb_s_q   <= SYNC_INIT;
      lk_s_q   <= SYNC_INIT;
      pb_lvl_q <= 1'b0;
      lk_lvl_q <= 1'b0;
    end else begin
      pb_s_q <= {pb_s_q[1:0], pushbutton_input};
      lk_s_q <= {lk_s_q[1:0], pll_locked};
      if (pb_s_q[1] == pb_s_q[2]) pb_lvl_q <= pb_s_q[2];
      if (lk_s_q[1] == lk_s_q[2]) lk_lvl_q <= lk_s_q[2];
    end
  end

  // One synchroniser per external interrupt input
  // Live inputs are filtered like the others, so a narrow glitch never reads back
  genvar gi;
  generate
    for (gi = 0; gi < N_EXT; gi++) begin : g_ext
      always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
          ext_s_q[gi]   <= SYNC_INIT;
          ext_lvl_q[gi] <= 1'b0;
        end else begin
          ext_s_q[gi] <= {ext_s_q[gi][1:0], ext_int_in[gi]};
          if (ext_s_q[gi][1] == ext_s_q[gi][2]) ext_lvl_q[gi] <= ext_s_q[gi][2];
        end
      end
    end
  endgenerate

  // Edge detection on the filtered levels, never on the first stage
  // Previous levels reset low, so a pin already high at release reads as an edge
  logic pb_prev_q;
  logic lk_prev_q;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pb_prev_q <= 1'b0;
      lk_prev_q <= 1'b0;
    end else begin
      pb_prev_q <= pb_lvl_q;
      lk_prev_q <= lk_lvl_q;
    end
  end

  wire pb_rise = pb_lvl_q & ~pb_prev_q;
  wire lk_rise = lk_lvl_q & ~lk_prev_q;
  // Only a real lock drop counts as power loss; wakes into brownout do not
  wire lk_fall = ~lk_lvl_q & lk_prev_q;

  ////////////////////////////////////////////////////////////////////////
  // Address decode
  // Exact compare on the full address; near misses must not alias a register
  wire hit_flag = (req.addr == FLAG_ADDR);
  wire hit_live = (req.addr == LIVE_ADDR);
  wire hit_ien  = (req.addr == IEN_ADDR);
  wire wr_flag  = req.wr & hit_flag;
  wire wr_ien   = req.wr & hit_ien;

  ////////////////////////////////////////////////////////////////////////
  // Flag sources and clears
  logic [7:0] flag_q;
  logic [7:0] flag_d;
  logic [7:0] set_v;
  logic [7:0] clr_v;

  always_comb begin
    set_v = ZERO_BYTE;
    set_v[BIT_XFER]  = evt.xfer;
    set_v[BIT_TICK]  = evt.tick;
    set_v[BIT_COL_A] = evt.col_a;
    set_v[BIT_COL_B] = evt.col_b;
    set_v[BIT_PB]    = pb_rise;
    set_v[BIT_WAKE]  = evt.wake_timer;
    set_v[BIT_RISE]  = lk_rise;
    set_v[BIT_FALL]  = lk_fall;
  end

  // Zero written clears, one written leaves alone
  always_comb begin
    clr_v = wr_flag ? ~req.wdata : ZERO_BYTE;
    clr_v[BIT_PB] = clr_v[BIT_PB] | evt.sleep_req;
  end

  // Set wins over any clear arriving in the same cycle
  assign flag_d = set_v | (flag_q & ~clr_v);

  // Reset and zero writes clear, sleep clears the pushbutton bit; wake does not, so boot code can read the source
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) flag_q <= FLAG_RESET;
    else       flag_q <= flag_d;
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt enable register
  // Only bits zero and four are stored; the rest of the byte is dropped
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      watchdog_near_overflow_irq_en <= EN_RESET;
      serial_port_irq_en            <= EN_RESET;
    end else if (wr_ien) begin
      watchdog_near_overflow_irq_en <= req.wdata[BIT_WD_EN];
      serial_port_irq_en            <= req.wdata[BIT_SPI_EN];
    end
  end

  // Power event: one-cycle pulse on either lock edge
  // Registered so it lines up with the flag bit that the same edge sets
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) power_event_interrupt <= 1'b0;
    else       power_event_interrupt <= lk_rise | lk_fall;
  end

  ////////////////////////////////////////////////////////////////////////
  // Read path; unmapped addresses return zero
  // Read data is held between reads, so a late sampler still sees it
  logic [7:0] ien_view;
  logic [7:0] live_view;
  logic [7:0] rd_mux;
  always_comb begin
    ien_view = ZERO_BYTE;
    ien_view[BIT_WD_EN]  = watchdog_near_overflow_irq_en;
    ien_view[BIT_SPI_EN] = serial_port_irq_en;
    live_view = ZERO_BYTE;
    live_view[N_EXT-1:0] = ext_lvl_q;
  end
  assign rd_mux = hit_flag ? flag_q :
                  hit_live ? live_view :
                  hit_ien  ? ien_view : ZERO_BYTE;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn)       rdata <= ZERO_BYTE;
    else if (req.rd) rdata <= rd_mux;
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  // Every flag has one setting source and one or two clearing paths
  sequence s_lock_rise;
    lk_lvl_q && !lk_prev_q;
  endsequence
  sequence s_lock_fall;
    !lk_lvl_q && lk_prev_q;
  endsequence

  a_pb_edge_set: assert property (@(posedge mclk) disable iff (!rstn)
    pb_rise |=> flag_q[BIT_PB]) else $error("pushbutton edge did not set flag");
  a_sleep_clears_pb: assert property (@(posedge mclk) disable iff (!rstn)
    evt.sleep_req && !pb_rise |=> !flag_q[BIT_PB]) else $error("sleep did not clear pb flag");
  a_pb_flag_holds: assert property (@(posedge mclk) disable iff (!rstn)
    flag_q[BIT_PB] && !evt.sleep_req && !(wr_flag && !req.wdata[BIT_PB])
    |=> flag_q[BIT_PB]) else $error("pb flag lost");
  a_rise_sets_flag: assert property (@(posedge mclk) disable iff (!rstn)
    s_lock_rise |=> flag_q[BIT_RISE] && power_event_interrupt)
    else $error("lock rise missed");
  a_fall_sets_flag: assert property (@(posedge mclk) disable iff (!rstn)
    s_lock_fall |=> flag_q[BIT_FALL] && power_event_interrupt)
    else $error("lock fall missed");
  a_fall_needs_edge: assert property (@(posedge mclk) disable iff (!rstn)
    $rose(flag_q[BIT_FALL]) |-> $past(lk_fall)) else $error("loss flag without lock fall");
  a_wake_sets_flag: assert property (@(posedge mclk) disable iff (!rstn)
    evt.wake_timer |=> flag_q[BIT_WAKE]) else $error("timer wake missed");
  a_event_flags: assert property (@(posedge mclk) disable iff (!rstn)
    evt.xfer && evt.tick |=> flag_q[BIT_XFER] && flag_q[BIT_TICK])
    else $error("xfer or tick flag missed");
  a_collision_bits: assert property (@(posedge mclk) disable iff (!rstn)
    evt.col_a && !evt.col_b && !flag_q[BIT_COL_B] && !(wr_flag && !req.wdata[BIT_COL_A])
    |=> flag_q[BIT_COL_A] && !flag_q[BIT_COL_B]) else $error("collision bit wrong");
  a_live_read: assert property (@(posedge mclk) disable iff (!rstn)
    req.rd && hit_live |=> rdata == {1'b0, $past(ext_lvl_q)}) else $error("live read wrong");
  a_enable_write: assert property (@(posedge mclk) disable iff (!rstn)
    wr_ien |=> serial_port_irq_en == $past(req.wdata[BIT_SPI_EN]) &&
    watchdog_near_overflow_irq_en == $past(req.wdata[BIT_WD_EN])) else $error("enable write");
  a_zero_write_clears: assert property (@(posedge mclk) disable iff (!rstn)
    wr_flag && !req.wdata[BIT_WAKE] && !evt.wake_timer |=> !flag_q[BIT_WAKE])
    else $error("zero write did not clear");
  a_set_beats_clear: assert property (@(posedge mclk) disable iff (!rstn)
    wr_flag && evt.xfer |=> flag_q[BIT_XFER]) else $error("clear beat set");
  a_one_write_keeps: assert property (@(posedge mclk) disable iff (!rstn)
    wr_flag && req.wdata[BIT_TICK] && flag_q[BIT_TICK] |=> flag_q[BIT_TICK])
    else $error("one write changed flag");

  // A zero written to the pushbutton bit clears it unless an edge arrives too
  sequence s_pb_zero_write;
    wr_flag && !req.wdata[BIT_PB] && !pb_rise;
  endsequence

  // Zero write clears the pushbutton flag
  a_pb_zero_clear: assert property (@(posedge mclk) disable iff (!rstn)
    s_pb_zero_write |=> !flag_q[BIT_PB])
    else $error("pb zero write did not clear");

  // Pushbutton flag rises only after a filtered edge
  a_pb_needs_edge: assert property (@(posedge mclk) disable iff (!rstn)
    $rose(flag_q[BIT_PB]) |-> $past(pb_rise))
    else $error("pb flag without edge");

  // Return flag rises only after a lock rise
  a_rise_needs_edge: assert property (@(posedge mclk) disable iff (!rstn)
    $rose(flag_q[BIT_RISE]) |-> $past(lk_rise))
    else $error("return flag without lock rise");

  // Power event only follows a lock edge
  a_power_from_edge: assert property (@(posedge mclk) disable iff (!rstn)
    power_event_interrupt |-> $past(lk_rise || lk_fall))
    else $error("power event without lock edge");

  // Filtered lock cannot toggle two cycles running, so the pulse is single
  a_power_one_cycle: assert property (@(posedge mclk) disable iff (!rstn)
    power_event_interrupt |=> !power_event_interrupt)
    else $error("power event too long");

  // Timer wake into brownout leaves the loss flag alone
  a_timer_no_loss: assert property (@(posedge mclk) disable iff (!rstn)
    evt.wake_timer && !lk_fall |=> !$rose(flag_q[BIT_FALL]))
    else $error("timer wake set loss flag");

  // Timer flag rises only from the expiry strobe
  a_wake_needs_event: assert property (@(posedge mclk) disable iff (!rstn)
    $rose(flag_q[BIT_WAKE]) |-> $past(evt.wake_timer))
    else $error("timer flag without expiry");

  // Transfer flag rises only from its strobe
  a_xfer_needs_event: assert property (@(posedge mclk) disable iff (!rstn)
    $rose(flag_q[BIT_XFER]) |-> $past(evt.xfer))
    else $error("transfer flag without event");

  // Second-tick flag rises only from its strobe
  a_tick_needs_event: assert property (@(posedge mclk) disable iff (!rstn)
    $rose(flag_q[BIT_TICK]) |-> $past(evt.tick))
    else $error("tick flag without event");

  // Second collision strobe lands in bit three
  a_col_b_set: assert property (@(posedge mclk) disable iff (!rstn)
    evt.col_b |=> flag_q[BIT_COL_B])
    else $error("collision b missed");

  // First collision flag rises only from its strobe
  a_col_a_needs: assert property (@(posedge mclk) disable iff (!rstn)
    $rose(flag_q[BIT_COL_A]) |-> $past(evt.col_a))
    else $error("collision a without event");

  // Read data changes only on a read
  a_rdata_holds: assert property (@(posedge mclk) disable iff (!rstn)
    !req.rd |=> $stable(rdata))
    else $error("read data moved without read");

  // Unmapped reads return zero
  a_unmapped_read: assert property (@(posedge mclk) disable iff (!rstn)
    req.rd && !hit_flag && !hit_live && !hit_ien |=> rdata == ZERO_BYTE)
    else $error("unmapped read not zero");

  // Enables change only on a write to their register
  a_enable_holds: assert property (@(posedge mclk) disable iff (!rstn)
    !wr_ien |=> $stable(serial_port_irq_en) && $stable(watchdog_near_overflow_irq_en))
    else $error("enable moved without write");

endmodule
`default_nettype wire

// ---- logic/wif_pkg.sv ----
// Purpose: Constants and carrier types for the wake and interrupt flag block
// Assumes: 8-bit special-function register port from the processor core
// Notes:   Offsets are the processor's own register addresses
package wif_pkg;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned NUM_EXT_INT = 7;
  // Register addresses
  localparam logic [15:0] FLAG_ADDR = 16'h00E8;
  localparam logic [15:0] LIVE_ADDR = 16'h00F8;
  localparam logic [15:0] IEN_ADDR  = 16'h20B0;
  // Flag register bit positions
  localparam int unsigned BIT_XFER  = 0;
  localparam int unsigned BIT_TICK  = 1;
  localparam int unsigned BIT_COL_A = 2;
  localparam int unsigned BIT_COL_B = 3;
  localparam int unsigned BIT_PB    = 4;
  localparam int unsigned BIT_WAKE  = 5;
  localparam int unsigned BIT_RISE  = 6;
  localparam int unsigned BIT_FALL  = 7;
  // Enable register bit positions
  localparam int unsigned BIT_WD_EN  = 0;
  localparam int unsigned BIT_SPI_EN = 4;
  localparam logic [7:0] FLAG_RESET = 8'h00;
  localparam logic       EN_RESET   = 1'b0;
  localparam logic [7:0] ZERO_BYTE  = 8'h00;
  localparam logic [2:0] SYNC_INIT  = 3'h0;

  // One processor register access
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } wif_req_t;

  // Hardware event strobes, one cycle each, same clock
  typedef struct packed {
    logic xfer;
    logic tick;
    logic col_a;
    logic col_b;
    logic wake_timer;
    logic sleep_req;
  } wif_evt_t;
endpackage

// ---- sim/tb.sv ----
// Purpose: Self-checking bench for the wake and interrupt flag block
// Assumes: Single-cycle strobe register port, reads answered one cycle later
// Notes:   Expected reads are queued by the driver and popped by a monitor
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin \
  total_checks++; \
  if ((got) !== (exp)) begin \
    failures++; \
    $display("mismatch at %0t: got %h exp %h", $time, got, exp); \
  end \
end
module tb;
  import wif_pkg::*;
  logic       mclk;
  logic       rstn;
  wif_req_t   req;
  wif_evt_t   evt;
  wif_evt_t   ev;
  logic       pb;
  logic       pll;
  logic [6:0] ext;
  logic [7:0] rdata;
  logic [7:0] exp_b;
  logic [7:0] exp_v;
  logic [7:0] exp_q[$];
  logic       pe;
  logic       wd_en;
  logic       sp_en;
  logic       rd_d;
  logic [31:0] seed;
  int         failures;
  int         total_checks;
  int         pe_cnt;

  wif_flags dut (.mclk(mclk), .rstn(rstn), .req(req), .evt(evt), .pushbutton_input(pb),
    .pll_locked(pll), .ext_int_in(ext), .rdata(rdata), .power_event_interrupt(pe),
    .watchdog_near_overflow_irq_en(wd_en), .serial_port_irq_en(sp_en));

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    lfsr_next = {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h00000000);
  endfunction

  // One strobe cycle; strobe dropped at the next edge so tasks chain safely
  task automatic acc(input logic w, input logic r, input logic [15:0] a,
                     input logic [7:0] d, input logic [7:0] e);
    @(posedge mclk);
    req <= '{wr: w, rd: r, addr: a, wdata: d};
    if (r) exp_q.push_back(e);
    @(posedge mclk);
    req <= '0;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    acc(1'b1, 1'b0, a, d, 8'h00);
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    acc(1'b0, 1'b1, a, 8'h00, e);
  endtask
  task automatic pulse(input wif_evt_t v);
    @(posedge mclk);
    evt <= v;
    @(posedge mclk);
    evt <= '0;
  endtask
  // Fixed waits cover the synchroniser latency of the async pins and let the last read check finish
  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic wrap_up();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, 20 ns period
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // Monitor: read data is settled by the falling edge after the taking edge
  always @(posedge mclk) rd_d <= req.rd;
  always @(posedge mclk) if (pe === 1'b1) pe_cnt++;
  always @(negedge mclk) begin
    if (rd_d === 1'b1) begin
      exp_v = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hXX;
      `CHK(rdata, exp_v)
    end
  end
  // Hang guard
  initial begin
    repeat (20000) @(posedge mclk);
    failures++;
    wrap_up();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rstn = 1'b0; req = '0; evt = '0; pb = 1'b0; pll = 1'b0; ext = 7'h00;
    rd_d = 1'b0; seed = 32'h07012FEB;
    repeat (20) @(posedge mclk);
    rstn <= 1'b1;
    rd(FLAG_ADDR, FLAG_RESET);
    rd(IEN_ADDR, 8'h00);
    wr(16'h1234, 8'hFF);
    rd(16'h1234, 8'h00);
    $display("test reset done");
    // Each flag-setting event alone; timer wake must not touch the loss bit
    for (int i = 0; i < 5; i++) begin
      ev = wif_evt_t'(6'h20 >> i);
      exp_b = (i == 4) ? 8'h20 : (8'h01 << i);
      pulse(ev);
      rd(FLAG_ADDR, exp_b);
      wr(FLAG_ADDR, 8'hFF);
      rd(FLAG_ADDR, exp_b);
      wr(FLAG_ADDR, ~exp_b);
      rd(FLAG_ADDR, 8'h00);
    end
    // Clear and set in one cycle, transfer and tick together: the sets win
    @(posedge mclk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: FLAG_ADDR, wdata: 8'h00};
    evt <= wif_evt_t'(6'h30);
    @(posedge mclk);
    req <= '0;
    evt <= '0;
    rd(FLAG_ADDR, 8'h03);
    wr(FLAG_ADDR, 8'h00);
    $display("test events done");
    pb <= 1'b1;
    idle(8);
    rd(FLAG_ADDR, 8'h10);
    pb <= 1'b0;
    idle(8);
    rd(FLAG_ADDR, 8'h10);
    pulse(wif_evt_t'(6'h01));
    rd(FLAG_ADDR, 8'h00);
    $display("test pushbutton done");
    pll <= 1'b1;
    idle(8);
    rd(FLAG_ADDR, 8'h40);
    `CHK(pe_cnt, 1)
    wr(FLAG_ADDR, 8'h00);
    pll <= 1'b0;
    idle(8);
    rd(FLAG_ADDR, 8'h80);
    `CHK(pe_cnt, 2)
    wr(FLAG_ADDR, 8'h00);
    $display("test power done");
    for (int i = 0; i < 6; i++) begin
      seed = lfsr_next(seed);
      ext <= seed[6:0];
      idle(6);
      rd(LIVE_ADDR, {1'b0, seed[6:0]});
    end
    $display("test live done");
    for (int i = 0; i < 5; i++) begin
      seed = lfsr_next(seed);
      exp_b = (i == 0) ? 8'hFF : seed[7:0];
      wr(IEN_ADDR, exp_b);
      rd(IEN_ADDR, exp_b & 8'h11);
      `CHK(wd_en, exp_b[0])
      `CHK(sp_en, exp_b[4])
    end
    $display("test enables done");
    idle(2);
    wrap_up();
  end
endmodule
`default_nettype wire
